// ===== design/tmr8_timer.sv
// Summary of operation
// - reset clears both internal compare output state bits to zero
// - nonzero output mode field puts the output state onto the pin in place of the port data
// - port direction bit still decides whether the pin is driven
// - pin override depends only on the output mode field, not the waveform mode
// - output state can be set up before the driver is enabled, but only once override is on
// - output mode zero leaves the output state alone on a match
// - a new output mode acts first at the next match after the write
// - force strobe in non-pwm modes applies the match action at once
// - only the waveform mode shapes the count sequence
// - non-pwm output mode sets, clears or toggles on match
// - waveform mode 0 only increments, wrapping 0xFF to 0x00
// - normal mode sets overflow flag as the counter becomes zero
// - counting only sets the overflow flag; service acknowledge clears it
// - the counter may be written at any time in normal mode
// - waveform mode 2 clears the counter when it equals compare value a
// - clear-on-match raises compare flag a once per period
// - compare value a writes act on the comparison immediately
// - compare value a below count misses until wrap past 0xFF
// - channel a mode 1 toggles its output state on each match
// - toggle frequency is io clock over 2*N*(1+compare value a)
// - clear-on-match sets overflow when counting from 0xFF to 0x00
// - a match sets its compare flag; writing one clears it
// - a counter write blocks all matches in the next timer clock
// - clock select zero stops counting; counter stays accessible
// - a counter write beats any clear or count in the same cycle
`timescale 1ns/1ps
`default_nettype none

module tmr8_timer (
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_tick,
	input  wire logic [2:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	input  wire logic       i_ovf_ack,
	input  wire logic [1:0] i_cmp_ack,
	input  wire logic [1:0] i_port_out,
	input  wire logic [1:0] i_port_dir,
	output logic      [1:0] o_pin_out,
	output logic      [1:0] o_pin_oe_b,
	output logic      [7:0] o_count,
	output logic            o_ovf_flag,
	output logic      [1:0] o_cmp_flag
);

	typedef struct packed {
		logic [1:0][1:0] com;
		logic [2:0]      wgm;
		logic [2:0]      cs;
		logic [7:0]      cnt;
		logic [1:0][7:0] ocr;
		logic            tov;
		logic [1:0]      ocf;
		logic [1:0]      oc;
		logic            block;
		logic [7:0]      rdata;
	} tmr8_state_t;

	tmr8_state_t q;
	tmr8_state_t d;

	logic       tick_en;
	logic       non_pwm;
	logic       wr_cnt;
	logic       clr_tov;
	logic [1:0] match;
	logic [1:0] force_hit;
	logic [1:0] act;
	logic [1:0] oc_next;

	function automatic logic oc_action(input logic [1:0] com, input logic oc);
		logic r;
		r = oc;
		case (com)
			tmr8_pkg::COM_TOGGLE: r = ~oc;
			tmr8_pkg::COM_CLEAR:  r = 1'b0;
			tmr8_pkg::COM_SET:    r = 1'b1;
			default:              r = oc;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// shared decode

	assign tick_en = i_tick && (q.cs != tmr8_pkg::CS_STOP);
	assign non_pwm = (q.wgm[0] == 1'b0);
	assign wr_cnt  = i_wr && (i_addr == tmr8_pkg::A_CNT);
	assign clr_tov = i_ovf_ack ||
		(i_wr && (i_addr == tmr8_pkg::A_FLAGS) && i_wdata[tmr8_pkg::TOV_BIT]);

	////////////////////////////////////////////////////////////////////////
	// per channel compare and pin override

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_ch
			// live compare value, no double buffer
			assign match[ch] = tick_en && !q.block && (q.cnt == q.ocr[ch]);
			assign force_hit[ch] = i_wr && (i_addr == tmr8_pkg::A_CTRL_B) &&
				i_wdata[tmr8_pkg::FOC_A_BIT - ch];
			assign act[ch] = non_pwm && (match[ch] || force_hit[ch]);
			assign oc_next[ch] = oc_action(q.com[ch], q.oc[ch]);
			// override follows mode field only
			assign o_pin_out[ch] = (q.com[ch] != tmr8_pkg::COM_NONE) ?
				q.oc[ch] : i_port_out[ch];
			assign o_pin_oe_b[ch] = ~i_port_dir[ch];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		d = q;
		d.rdata = 8'h00;
		if (i_rd) begin
			case (i_addr)
				tmr8_pkg::A_CTRL_A: begin
					d.rdata[tmr8_pkg::COM_A_LSB +: 2] = q.com[0];
					d.rdata[tmr8_pkg::COM_B_LSB +: 2] = q.com[1];
					d.rdata[tmr8_pkg::WGM_LO_LSB +: 2] = q.wgm[1:0];
				end
				tmr8_pkg::A_CTRL_B: begin
					d.rdata[tmr8_pkg::WGM_HI_BIT] = q.wgm[2];
					d.rdata[tmr8_pkg::CS_LSB +: 3] = q.cs;
				end
				tmr8_pkg::A_CNT:   d.rdata = q.cnt;
				tmr8_pkg::A_CMP_A: d.rdata = q.ocr[0];
				tmr8_pkg::A_CMP_B: d.rdata = q.ocr[1];
				tmr8_pkg::A_FLAGS: begin
					d.rdata[tmr8_pkg::TOV_BIT] = q.tov;
					d.rdata[tmr8_pkg::OCF_A_BIT] = q.ocf[0];
					d.rdata[tmr8_pkg::OCF_B_BIT] = q.ocf[1];
				end
				tmr8_pkg::A_OUT: d.rdata[1:0] = q.oc;
				default: d.rdata = 8'h00;
			endcase
		end

		// counting, sequence from waveform mode only
		if (tick_en) begin
			d.block = 1'b0;
			if ((q.wgm == tmr8_pkg::WGM_CTC) && match[0]) begin
				d.cnt = tmr8_pkg::CNT_BOT;
			end else begin
				d.cnt = q.cnt + 8'h01;
			end
		end

		// bus writes after counting so they take priority
		if (i_wr) begin
			case (i_addr)
				tmr8_pkg::A_CTRL_A: begin
					d.com[0] = i_wdata[tmr8_pkg::COM_A_LSB +: 2];
					d.com[1] = i_wdata[tmr8_pkg::COM_B_LSB +: 2];
					d.wgm[1:0] = i_wdata[tmr8_pkg::WGM_LO_LSB +: 2];
				end
				tmr8_pkg::A_CTRL_B: begin
					d.wgm[2] = i_wdata[tmr8_pkg::WGM_HI_BIT];
					d.cs = i_wdata[tmr8_pkg::CS_LSB +: 3];
				end
				tmr8_pkg::A_CNT: begin
					d.cnt = i_wdata;
					d.block = 1'b1;
				end
				tmr8_pkg::A_CMP_A: d.ocr[0] = i_wdata;
				tmr8_pkg::A_CMP_B: d.ocr[1] = i_wdata;
				tmr8_pkg::A_FLAGS: begin
					if (i_wdata[tmr8_pkg::OCF_A_BIT]) begin
						d.ocf[0] = 1'b0;
					end
					if (i_wdata[tmr8_pkg::OCF_B_BIT]) begin
						d.ocf[1] = 1'b0;
					end
				end
				default: d.block = d.block;
			endcase
		end

		// service acknowledges
		if (clr_tov) begin
			d.tov = 1'b0;
		end
		d.ocf = d.ocf & ~i_cmp_ack;

		// hardware sets last, so a set beats a same-cycle clear
		if (tick_en && (q.cnt == tmr8_pkg::CNT_MAX)) begin
			d.tov = 1'b1;
		end
		d.ocf = d.ocf | match;
		for (int i = 0; i < 2; i++) begin
			if (act[i]) begin
				d.oc[i] = oc_next[i];
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_rdata    = q.rdata;
	assign o_count    = q.cnt;
	assign o_ovf_flag = q.tov;
	assign o_cmp_flag = q.ocf;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	chk_pin_override: assert property (
		(q.com[0] != 2'h0) |-> (o_pin_out[0] == q.oc[0]))
		else $error("pin a not overridden by output state");

	chk_pin_direction: assert property (
		o_pin_oe_b == ~i_port_dir)
		else $error("pin enable not following direction bit");

	chk_mode_zero_hold: assert property (
		(q.com[0] == 2'h0) |=> (q.oc[0] == $past(q.oc[0])))
		else $error("output state changed with mode zero");

	chk_normal_wrap: assert property (
		(tick_en && !wr_cnt && (q.wgm == 3'h0) && (q.cnt == 8'hFF))
		|=> (q.cnt == 8'h00) && q.tov)
		else $error("normal wrap or overflow flag wrong");

	chk_ctc_clear: assert property (
		(tick_en && !wr_cnt && !q.block && (q.wgm == 3'h2) && (q.cnt == q.ocr[0]))
		|=> (q.cnt == 8'h00) && q.ocf[0])
		else $error("clear on match failed");

	chk_ctc_toggle: assert property (
		((q.wgm == 3'h2) && (q.com[0] == 2'h1) && match[0])
		|=> (q.oc[0] != $past(q.oc[0])))
		else $error("toggle missing on match");

	chk_write_blocks: assert property (
		(q.block && tick_en) |=> !$rose(q.ocf[0]) && !$rose(q.ocf[1]))
		else $error("match not blocked after counter write");

	chk_write_wins: assert property (
		wr_cnt |=> (q.cnt == $past(i_wdata)))
		else $error("counter write lost");

	chk_stop_holds: assert property (
		((q.cs == 3'h0) && !wr_cnt) |=> $stable(q.cnt))
		else $error("counter moved while stopped");

	chk_tov_sticky: assert property (
		(q.tov && !clr_tov) |=> q.tov)
		else $error("overflow flag cleared by counting");

	chk_ovf_set: assert property (
		(tick_en && (q.cnt == 8'hFF)) |=> q.tov)
		else $error("overflow flag not set at wrap");

	chk_tov_clear: assert property (
		(clr_tov && !(tick_en && (q.cnt == 8'hFF))) |=> !q.tov)
		else $error("overflow flag not cleared by acknowledge");

	chk_ctc_flag: assert property (
		((q.wgm == 3'h2) && match[0]) |=> q.ocf[0])
		else $error("compare flag a missing at top");

	chk_match_flag: assert property (
		match[1] |=> q.ocf[1])
		else $error("compare flag b missing on match");

	chk_ocf_clear: assert property (
		(i_cmp_ack[0] && !match[0]) |=> !q.ocf[0])
		else $error("compare flag a not cleared");

	chk_force_set: assert property (
		(force_hit[0] && non_pwm && (q.com[0] == 2'h3)) |=> q.oc[0])
		else $error("force did not set output state");

	chk_force_no_flag: assert property (
		(force_hit[1] && !match[1] && !q.ocf[1]) |=> !q.ocf[1])
		else $error("force raised a compare flag");

	chk_block_set: assert property (
		wr_cnt |=> q.block)
		else $error("counter write did not arm block");

	chk_ctc_missed: assert property (
		((q.wgm == 3'h2) && tick_en && !wr_cnt && (q.cnt == 8'hFF) && (q.ocr[0] != 8'hFF))
		|=> (q.cnt == 8'h00))
		else $error("missed top did not wrap");

	chk_cmp_live: assert property (
		(i_wr && (i_addr == tmr8_pkg::A_CMP_A)) |=> (q.ocr[0] == $past(i_wdata)))
		else $error("compare value a not taken at once");

	chk_normal_step: assert property (
		(tick_en && !wr_cnt && (q.wgm == 3'h0)) |=> (q.cnt == $past(q.cnt) + 8'h01))
		else $error("normal mode did not increment");

	chk_cnt_idle: assert property (
		(!tick_en && !wr_cnt) |=> $stable(q.cnt))
		else $error("counter moved without timer clock");

	chk_oc_hold: assert property (
		!act[0] |=> $stable(q.oc[0]))
		else $error("output state moved without action");

	chk_pwm_no_action: assert property (
		!non_pwm |=> $stable(q.oc))
		else $error("output state moved in pwm mode");

	chk_pin_port_b: assert property (
		(q.com[1] == 2'h0) |-> (o_pin_out[1] == i_port_out[1]))
		else $error("pin b not following port data");

	chk_override_b: assert property (
		(q.com[1] != 2'h0) |-> (o_pin_out[1] == q.oc[1]))
		else $error("pin b not overridden by output state");

	chk_mode_zero_b: assert property (
		(q.com[1] == 2'h0) |=> (q.oc[1] == $past(q.oc[1])))
		else $error("output state b changed with mode zero");

	chk_rdata_idle: assert property (
		!i_rd |=> (o_rdata == 8'h00))
		else $error("read data not idle");

	cov_wrap_normal: cover property ((q.wgm == 3'h0) && tick_en && (q.cnt == 8'hFF));
	cov_ctc_period: cover property (
		(q.wgm == 3'h2) && match[0] ##1 (q.cnt == 8'h00));
	cov_force_out: cover property (non_pwm && force_hit[0] && (q.com[0] != 2'h0));
	cov_missed_top: cover property (
		(q.wgm == 3'h2) && tick_en && (q.cnt == 8'hFF) && (q.ocr[0] != 8'hFF));
	cov_set_vs_clear: cover property (match[0] && (i_cmp_ack[0] || i_wr));

endmodule

`default_nettype wire

// ===== dv/tmr8_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmr8_port_model (
	input  wire logic       i_clk,
	input  wire logic [1:0] i_data,
	input  wire logic [1:0] i_dir,
	input  wire logic [1:0] i_drv,
	input  wire logic [1:0] i_drv_oe_b,
	output logic      [1:0] o_port_out,
	output logic      [1:0] o_port_dir,
	output logic      [1:0] o_pin
);
	logic [1:0] last_q = 2'h0;
	assign o_port_out = i_data;
	assign o_port_dir = i_dir;
	// no pull: an undriven pin wanders
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			o_pin[k] = i_drv_oe_b[k] ? ~last_q[k] : i_drv[k];
		end
	end
	always_ff @(posedge i_clk) begin
		last_q <= o_pin;
	end
endmodule
`default_nettype wire

// ===== dv/tmr8_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tmr8_timer_tb_top;
	localparam logic [2:0] CA = tmr8_pkg::A_CTRL_A;
	localparam logic [2:0] CB = tmr8_pkg::A_CTRL_B;
	localparam logic [2:0] CN = tmr8_pkg::A_CNT;
	localparam logic [2:0] CM = tmr8_pkg::A_CMP_A;
	localparam logic [2:0] FL = tmr8_pkg::A_FLAGS;
	localparam logic [2:0] OS = tmr8_pkg::A_OUT;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        tick = 1'b0;
	logic [2:0]  addr = 3'h0;
	logic [7:0]  wdata = 8'h00;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        ovf_ack = 1'b0;
	logic [1:0]  cmp_ack = 2'h0;
	logic [1:0]  pdata = 2'h0;
	logic [1:0]  pdir = 2'h0;
	logic [7:0]  rdata;
	logic [1:0]  port_out;
	logic [1:0]  port_dir;
	logic [1:0]  pin_out;
	logic [1:0]  pin_oe_b;
	logic [1:0]  pin;
	logic [7:0]  cnt_o;
	logic        ovf;
	logic [1:0]  cmpf;
	logic        rd_q = 1'b0;
	logic [15:0] rnd = 16'h305F;
	logic [7:0]  c;
	logic [7:0]  eq[$];
	string       nq[$];
	int          failures = 0;
	int          checks = 0;
	int          cyc = 0;

	always #5 clk = ~clk;

	tmr8_timer DUT (.i_clk(clk), .i_rst_b(rst_b), .i_tick(tick), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ovf_ack(ovf_ack),
		.i_cmp_ack(cmp_ack), .i_port_out(port_out), .i_port_dir(port_dir),
		.o_pin_out(pin_out), .o_pin_oe_b(pin_oe_b), .o_count(cnt_o), .o_ovf_flag(ovf),
		.o_cmp_flag(cmpf));
	tmr8_port_model PORT (.i_clk(clk), .i_data(pdata), .i_dir(pdir), .i_drv(pin_out),
		.i_drv_oe_b(pin_oe_b), .o_port_out(port_out), .o_port_dir(port_dir), .o_pin(pin));
	////////////////////////////////////////
	task finish_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		checks++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task wr8(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd8(input logic [2:0] a, input logic [7:0] e, input string n);
		eq.push_back(e);
		nq.push_back(n);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task tk(input int n);
		@(posedge clk);
		tick <= 1'b1;
		repeat (n) @(posedge clk);
		tick <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	always @(posedge clk) begin
		rd_q <= rd;
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			failures++;
			finish_test();
		end
	end
	always @(negedge clk) begin
		if (rd_q) begin
			chk(nq.pop_front(), eq.pop_front(), rdata);
		end
	end
	////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		pdata <= rnd[1:0];
		for (int a = 0; a < 8; a++) rd8(a[2:0], 8'h00, "reset");
		@(negedge clk);
		chk("pin_out", {6'h0, pdata}, {6'h0, pin_out});
		chk("pin_oe_b", 8'h03, {6'h0, pin_oe_b});
		$display("test reset done");
		wr8(CN, 8'hFE);
		wr8(CB, 8'h01);
		tk(2);
		rd8(CN, 8'h00, "count wrap");
		rd8(FL, 8'h01, "overflow");
		tk(1);
		@(negedge clk);
		chk("count", 8'h01, cnt_o);
		chk("ovf_flag", 8'h01, {7'h0, ovf});
		chk("cmp_flag", 8'h03, {6'h0, cmpf});
		rd8(FL, 8'h07, "flags");
		@(posedge clk);
		ovf_ack <= 1'b1;
		@(posedge clk);
		ovf_ack <= 1'b0;
		rd8(FL, 8'h06, "ovf ack");
		@(posedge clk);
		cmp_ack <= 2'h3;
		@(posedge clk);
		cmp_ack <= 2'h0;
		rd8(FL, 8'h00, "cmp ack");
		wr8(CB, 8'h00);
		tk(3);
		rd8(CN, 8'h01, "stopped");
		rnd = lfsr(rnd);
		c = {1'b0, rnd[6:0]} | 8'h01;
		wr8(CM, c);
		wr8(CN, c);
		wr8(CB, 8'h01);
		tk(1);
		rd8(FL, 8'h00, "blocked");
		rd8(CN, c + 8'h01, "count");
		rnd = lfsr(rnd);
		fork
			tk(3);
			wr8(CN, rnd[7:0]);
		join
		rd8(CN, rnd[7:0] + 8'h02, "write priority");
		$display("test normal done");
		wr8(CA, {tmr8_pkg::COM_SET, 6'h00});
		wr8(CB, 8'h80);
		rd8(OS, 8'h01, "force set");
		@(negedge clk);
		chk("pin_oe_b", 8'h03, {6'h0, pin_oe_b});
		@(posedge clk);
		pdir <= 2'h1;
		@(negedge clk);
		chk("pin", 8'h01, {7'h0, pin[0]});
		for (int m = 1; m < 5; m++) begin
			wr8(CA, {m[1:0], 6'h00});
			wr8(CB, 8'h80);
			rd8(OS, {7'h0, m > 2}, "force action");
		end
		@(negedge clk);
		chk("pin", {7'h0, pdata[0]}, {7'h0, pin[0]});
		wr8(CA, {2'h0, tmr8_pkg::COM_SET, 4'h0});
		wr8(CB, 8'h40);
		rd8(OS, 8'h03, "force b");
		$display("test force done");
		rnd = lfsr(rnd);
		c = {5'h0, rnd[2:0]} + 8'h01;
		wr8(tmr8_pkg::A_CMP_B, 8'h40);
		wr8(CA, {tmr8_pkg::COM_TOGGLE, 4'h0, tmr8_pkg::WGM_CTC[1:0]});
		wr8(CM, c);
		wr8(CN, 8'h00);
		wr8(FL, 8'h07);
		wr8(CB, 8'h01);
		tk(c + 1);
		rd8(CN, 8'h00, "ctc clear");
		rd8(FL, 8'h02, "ctc flag");
		rd8(OS, 8'h02, "ctc toggle");
		@(negedge clk);
		chk("pin", 8'h00, {7'h0, pin[0]});
		wr8(FL, 8'h02);
		rd8(FL, 8'h00, "flag clear");
		tk(c + 1);
		rd8(OS, 8'h03, "ctc period");
		wr8(CA, {tmr8_pkg::COM_CLEAR, 4'h0, tmr8_pkg::WGM_CTC[1:0]});
		rd8(OS, 8'h03, "mode write");
		tk(c + 1);
		rd8(OS, 8'h02, "mode next match");
		wr8(CN, 8'h20);
		wr8(CM, 8'h02);
		wr8(FL, 8'h07);
		tk(224);
		rd8(CN, 8'h00, "ctc wrap");
		rd8(FL, 8'h05, "ctc overflow");
		tk(3);
		rd8(FL, 8'h07, "late match");
		$display("test ctc done");
		finish_test();
	end
endmodule
`default_nettype wire

// ===== inc/tmr8_pkg.sv
package tmr8_pkg;
	// register indices on the plain port
	localparam logic [2:0] A_CTRL_A = 3'h0;
	localparam logic [2:0] A_CTRL_B = 3'h1;
	localparam logic [2:0] A_CNT    = 3'h2;
	localparam logic [2:0] A_CMP_A  = 3'h3;
	localparam logic [2:0] A_CMP_B  = 3'h4;
	localparam logic [2:0] A_FLAGS  = 3'h5;
	localparam logic [2:0] A_OUT    = 3'h6;

	// timer_control_a fields
	localparam int COM_A_LSB = 6;
	localparam int COM_B_LSB = 4;
	localparam int WGM_LO_LSB = 0;
	// timer_control_b fields
	localparam int FOC_A_BIT = 7;
	localparam int FOC_B_BIT = 6;
	localparam int WGM_HI_BIT = 3;
	localparam int CS_LSB = 0;
	// flag register fields
	localparam int TOV_BIT = 0;
	localparam int OCF_A_BIT = 1;
	localparam int OCF_B_BIT = 2;

	// waveform_mode_select codes
	localparam logic [2:0] WGM_NORMAL = 3'h0;
	localparam logic [2:0] WGM_CTC    = 3'h2;

	// compare_output_mode_field codes, non-pwm modes
	localparam logic [1:0] COM_NONE   = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR  = 2'h2;
	localparam logic [1:0] COM_SET    = 2'h3;

	localparam logic [2:0] CS_STOP  = 3'h0;
	localparam logic [7:0] CNT_MAX  = 8'hFF;
	localparam logic [7:0] CNT_BOT  = 8'h00;
	localparam logic [7:0] RST_BYTE = 8'h00;
endpackage
